// file: iocr_pkg.sv
package iocr_pkg;

  // ****************************************************************
  // Register offsets within the 256-byte window
  // ****************************************************************
  localparam logic [7:0] OFF_PORT_A_PIN_LEVELS = 8'h00;
  localparam logic [7:0] OFF_PORT_B_PIN_LEVELS = 8'h01;
  localparam logic [7:0] OFF_PORT_A_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFF_PORT_B_OUTPUT_LATCH = 8'h05;
  localparam logic [7:0] OFF_PORT_A_PIN_DIR = 8'h06;
  localparam logic [7:0] OFF_PORT_B_PIN_DIR = 8'h07;
  localparam logic [7:0] OFF_PORT_A_DRIVE_TYPE = 8'h08;
  localparam logic [7:0] OFF_PORT_B_DRIVE_TYPE = 8'h09;
  localparam logic [7:0] OFF_PORT_A_IN_CELLS = 8'h0A;
  localparam logic [7:0] OFF_PORT_B_IN_CELLS = 8'h0B;
  localparam logic [7:0] OFF_PORT_A_OE_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PORT_B_OE_STATUS = 8'h0D;
  localparam logic [7:0] OFF_PORT_C_PIN_LEVELS = 8'h10;
  localparam logic [7:0] OFF_PORT_D_PIN_LEVELS = 8'h11;
  localparam logic [7:0] OFF_PORT_C_OUTPUT_LATCH = 8'h14;
  localparam logic [7:0] OFF_PORT_D_OUTPUT_LATCH = 8'h15;
  localparam logic [7:0] OFF_PORT_C_PIN_DIR = 8'h16;
  localparam logic [7:0] OFF_PORT_D_PIN_DIR = 8'h17;
  localparam logic [7:0] OFF_PORT_C_DRIVE_TYPE = 8'h18;
  localparam logic [7:0] OFF_PORT_D_DRIVE_TYPE = 8'h19;
  localparam logic [7:0] OFF_PORT_D_IN_CELLS = 8'h1A;
  localparam logic [7:0] OFF_PORT_C_OE_STATUS = 8'h1C;
  localparam logic [7:0] OFF_LOGIC_CELLS_A_STATE = 8'h20;
  localparam logic [7:0] OFF_LOGIC_CELLS_B_STATE = 8'h21;
  localparam logic [7:0] OFF_LOGIC_CELLS_A_WRITE_LOCK = 8'h22;
  localparam logic [7:0] OFF_LOGIC_CELLS_B_WRITE_LOCK = 8'h23;
  localparam logic [7:0] OFF_PORT_E_PIN_LEVELS = 8'h30;
  localparam logic [7:0] OFF_PORT_E_PIN_FUNCTION = 8'h32;
  localparam logic [7:0] OFF_PORT_E_OUTPUT_LATCH = 8'h34;
  localparam logic [7:0] OFF_PORT_E_PIN_DIR = 8'h36;
  localparam logic [7:0] OFF_PORT_E_DRIVE_TYPE = 8'h38;
  localparam logic [7:0] OFF_PORT_F_PIN_LEVELS = 8'h40;
  localparam logic [7:0] OFF_PORT_G_PIN_LEVELS = 8'h41;
  localparam logic [7:0] OFF_PORT_F_PIN_FUNCTION = 8'h42;
  localparam logic [7:0] OFF_PORT_G_PIN_FUNCTION = 8'h43;
  localparam logic [7:0] OFF_PORT_F_OUTPUT_LATCH = 8'h44;
  localparam logic [7:0] OFF_PORT_G_OUTPUT_LATCH = 8'h45;
  localparam logic [7:0] OFF_PORT_F_PIN_DIR = 8'h46;
  localparam logic [7:0] OFF_PORT_G_PIN_DIR = 8'h47;
  localparam logic [7:0] OFF_PORT_F_DRIVE_TYPE = 8'h48;
  localparam logic [7:0] OFF_PORT_G_DRIVE_TYPE = 8'h49;
  localparam logic [7:0] OFF_PORT_F_OE_STATUS = 8'h4C;
  localparam logic [7:0] OFF_PRIMARY_SECTOR_LOCK_STATUS = 8'hC0;
  localparam logic [7:0] OFF_SECONDARY_SECTOR_LOCK_STATUS = 8'hC2;
  localparam logic [7:0] OFF_DEBUG_PORT_GATE = 8'hC7;
  localparam logic [7:0] OFF_ADDRESS_PAGE_SELECT = 8'hE0;
  localparam logic [7:0] OFF_MEMORY_SPACE_PLACEMENT = 8'hE2;
  localparam logic [7:0] OFF_MEMORY_SIZE_INFO0 = 8'hF0;
  localparam logic [7:0] OFF_MEMORY_SIZE_INFO1 = 8'hF1;

  // ****************************************************************
  // Reset values, field positions and counts
  // ****************************************************************
  localparam int NUM_PORTS = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_PLACEMENT = 8'h00;
  localparam int POS_DEBUG_ENABLE = 0;
  localparam int POS_SECURITY = 7;
  localparam int POS_READY_BUSY = 4;
  localparam int POS_BATTERY_ON = 7;
  localparam logic [7:0] MEM_SIZE_INFO0_VALUE = 8'h00;
  localparam logic [7:0] MEM_SIZE_INFO1_VALUE = 8'h00;

  // Port index encoding, A=0 .. G=6.
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;

  // One host register access.
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [7:0] wdata;
  } iocr_bus_t;

  // Pin-side signals of one port.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] open_drain;
  } iocr_pin_t;

endpackage : iocr_pkg

// file: iocr_port.sv
module iocr_port (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Write strobes from the decoder
  input wire logic i_wr_out,
  input wire logic i_wr_dir,
  input wire logic i_wr_drive,
  input wire logic i_wr_func,
  input wire logic [7:0] i_wdata,
  // Alternate sources
  input wire logic [7:0] i_latched_addr,
  input wire logic i_has_func,
  input wire logic i_drive_is_od,
  // Register contents and pin drive
  output logic [7:0] o_out_latch,
  output logic [7:0] o_dir,
  output logic [7:0] o_drive,
  output logic [7:0] o_func,
  output iocr_pkg::iocr_pin_t o_pin
);

  // ****************************************************************
  // Per-port configuration storage
  // ****************************************************************
  logic [7:0] out_reg;
  logic [7:0] dir_reg;
  logic [7:0] drive_reg;
  logic [7:0] func_reg;

  // Host writes land here; direction clears to input at reset.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_reg <= iocr_pkg::RESET_BYTE;
      dir_reg <= iocr_pkg::RESET_BYTE;
      drive_reg <= iocr_pkg::RESET_BYTE;
      func_reg <= iocr_pkg::RESET_BYTE;
    end else begin
      if (i_wr_out) out_reg <= i_wdata;
      if (i_wr_dir) dir_reg <= i_wdata;
      if (i_wr_drive) drive_reg <= i_wdata;
      if (i_wr_func && i_has_func) func_reg <= i_wdata;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Address-out pins drive whatever the direction bit says; otherwise the direction bit decides.
  // Open-drain pins only drive a low level, so a high is released.
  wire [7:0] value_w = (func_reg & i_latched_addr) | (~func_reg & out_reg);
  wire [7:0] enable_w = func_reg | dir_reg;
  wire [7:0] od_w = i_drive_is_od ? drive_reg : 8'h00;

  assign o_pin.out = value_w;
  assign o_pin.oe = enable_w & ~(od_w & value_w);
  assign o_pin.open_drain = od_w;
  assign o_out_latch = out_reg;
  assign o_dir = dir_reg;
  assign o_drive = drive_reg;
  assign o_func = i_has_func ? func_reg : 8'h00;

endmodule : iocr_port

// file: iocr_top.sv
// Functional notes
// - Decode 256-byte window at user base
// - Data-in reads return live pin levels
// - Ports E,F,G mode registers at 32,42,43
// - Data-out latch drives host-controlled output pins
// - Direction register sets each pin's direction
// - Drive select: open-drain or slew per port
// - Read-only output-enable status for A,B,C,F
// - Macrocell registers read outputs, writes load
// - Mask registers block macrocell host writes
// - C0 reports primary sector write protection
// - C2 reports security and secondary protection
// - E2 places memories in program/data space
// - F0 reports SRAM and primary flash size
// - F1 reports secondary memory type, size
// - Port E pin 4 shows ready/busy only while programming runs
// - Port E pin 7 shows battery-on flag
// - Non-multiplexed bus: F is D0-7, G D8-15
// - Direction bit clear is input, default
// - Mode bit clear is general I/O, default
// - Set mask bit ignores macrocell host write
module iocr_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Host register access
  input wire logic i_register_window_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_offset,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Host data bus in non-multiplexed configuration
  input wire logic i_nonmux_bus,
  input wire logic i_host_data_drive,
  input wire logic [15:0] i_host_data,
  input wire logic [15:0] i_latched_addr,
  // Port pins A..G, index 0 = A
  input wire logic [7:0] i_pin [7],
  output logic [7:0] o_pin_out [7],
  output logic [7:0] o_pin_oe [7],
  // Programmable logic state
  input wire logic [7:0] i_in_cells_a,
  input wire logic [7:0] i_in_cells_b,
  input wire logic [7:0] i_in_cells_d,
  input wire logic [7:0] i_cells_a_next,
  input wire logic [7:0] i_cells_b_next,
  input wire logic i_cells_clock_en,
  output logic [7:0] o_logic_cells_a,
  output logic [7:0] o_logic_cells_b,
  output logic [7:0] o_page_bits,
  // Flash and memory status
  input wire logic [7:0] i_primary_sector_lock,
  input wire logic [3:0] i_secondary_sector_lock,
  input wire logic i_security_set,
  input wire logic i_isp_active,
  input wire logic i_isp_ready,
  input wire logic i_rdy_busy_enable,
  input wire logic i_battery_on_flag,
  input wire logic i_battery_flag_enable,
  output logic [7:0] o_memory_space_placement,
  output logic o_debug_port_enable
);

  // ****************************************************************
  // Access decode
  // ****************************************************************
  // The base comparison lives outside; the select marks a window hit.
  // Both strobes count only with the window selected.
  wire rd_w = i_register_window_select & i_rd;
  wire wr_w = i_register_window_select & i_wr;
  wire [7:0] off_w = i_offset;

  // Write strobes of the registers outside the ports.
  wire wr_lock_a_w = wr_w && off_w == iocr_pkg::OFF_LOGIC_CELLS_A_WRITE_LOCK;
  wire wr_lock_b_w = wr_w && off_w == iocr_pkg::OFF_LOGIC_CELLS_B_WRITE_LOCK;
  wire wr_page_w = wr_w && off_w == iocr_pkg::OFF_ADDRESS_PAGE_SELECT;
  wire wr_place_w = wr_w && off_w == iocr_pkg::OFF_MEMORY_SPACE_PLACEMENT;
  wire wr_debug_w = wr_w && off_w == iocr_pkg::OFF_DEBUG_PORT_GATE;

  // Per-port register offsets, A..G.
  localparam logic [7:0] OUT_OFF [7] = '{
    iocr_pkg::OFF_PORT_A_OUTPUT_LATCH, iocr_pkg::OFF_PORT_B_OUTPUT_LATCH,
    iocr_pkg::OFF_PORT_C_OUTPUT_LATCH, iocr_pkg::OFF_PORT_D_OUTPUT_LATCH,
    iocr_pkg::OFF_PORT_E_OUTPUT_LATCH, iocr_pkg::OFF_PORT_F_OUTPUT_LATCH,
    iocr_pkg::OFF_PORT_G_OUTPUT_LATCH};

  localparam logic [7:0] DIR_OFF [7] = '{
    iocr_pkg::OFF_PORT_A_PIN_DIR, iocr_pkg::OFF_PORT_B_PIN_DIR,
    iocr_pkg::OFF_PORT_C_PIN_DIR, iocr_pkg::OFF_PORT_D_PIN_DIR,
    iocr_pkg::OFF_PORT_E_PIN_DIR, iocr_pkg::OFF_PORT_F_PIN_DIR,
    iocr_pkg::OFF_PORT_G_PIN_DIR};

  localparam logic [7:0] DRV_OFF [7] = '{
    iocr_pkg::OFF_PORT_A_DRIVE_TYPE, iocr_pkg::OFF_PORT_B_DRIVE_TYPE,
    iocr_pkg::OFF_PORT_C_DRIVE_TYPE, iocr_pkg::OFF_PORT_D_DRIVE_TYPE,
    iocr_pkg::OFF_PORT_E_DRIVE_TYPE, iocr_pkg::OFF_PORT_F_DRIVE_TYPE,
    iocr_pkg::OFF_PORT_G_DRIVE_TYPE};

  localparam logic [7:0] IN_OFF [7] = '{
    iocr_pkg::OFF_PORT_A_PIN_LEVELS, iocr_pkg::OFF_PORT_B_PIN_LEVELS,
    iocr_pkg::OFF_PORT_C_PIN_LEVELS, iocr_pkg::OFF_PORT_D_PIN_LEVELS,
    iocr_pkg::OFF_PORT_E_PIN_LEVELS, iocr_pkg::OFF_PORT_F_PIN_LEVELS,
    iocr_pkg::OFF_PORT_G_PIN_LEVELS};

  // Mode registers exist only on E, F and G; others point at an unused slot.
  localparam logic [7:0] FUNC_OFF [7] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF,
    iocr_pkg::OFF_PORT_E_PIN_FUNCTION, iocr_pkg::OFF_PORT_F_PIN_FUNCTION,
    iocr_pkg::OFF_PORT_G_PIN_FUNCTION};

  // Bit n of these masks stands for port n.
  localparam logic [6:0] HAS_FUNC = 7'h70;

  // Ports C and F select slew rate, the rest select open drain.
  localparam logic [6:0] DRIVE_IS_OD = 7'h5B;

  // ****************************************************************
  // Ports
  // ****************************************************************
  // Register contents and pin drive, one entry per port.
  logic [7:0] out_latch_w [7];
  logic [7:0] dir_w [7];
  logic [7:0] drive_w [7];
  logic [7:0] func_w [7];
  logic [7:0] oe_w [7];
  logic [7:0] level_w [7];
  logic [7:0] pin_out_w [7];

  // One port instance each; the offset tables tell them apart.
  genvar gi;
  generate
    for (gi = 0; gi < iocr_pkg::NUM_PORTS; gi++) begin : g_port
      iocr_pkg::iocr_pin_t pin_w;
      logic [7:0] addr_src_w;
      // E takes the low address byte, F and G the low and high bytes.
      assign addr_src_w = (gi == iocr_pkg::PORT_G) ? i_latched_addr[15:8] : i_latched_addr[7:0];

      // Write strobes of this port's registers.
      wire wr_out_w = wr_w && off_w == OUT_OFF[gi];
      wire wr_dir_w = wr_w && off_w == DIR_OFF[gi];
      wire wr_drive_w = wr_w && off_w == DRV_OFF[gi];
      wire wr_func_w = wr_w && off_w == FUNC_OFF[gi];
      iocr_port u_port (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_wr_out(wr_out_w),
        .i_wr_dir(wr_dir_w),
        .i_wr_drive(wr_drive_w),
        .i_wr_func(wr_func_w),
        .i_wdata(i_wdata),
        .i_latched_addr(addr_src_w),
        .i_has_func(HAS_FUNC[gi]),
        .i_drive_is_od(DRIVE_IS_OD[gi]),
        .o_out_latch(out_latch_w[gi]),
        .o_dir(dir_w[gi]),
        .o_drive(drive_w[gi]),
        .o_func(func_w[gi]),
        .o_pin(pin_w)
      );
      assign pin_out_w[gi] = pin_w.out;
      assign oe_w[gi] = pin_w.oe;
      // Pins driven by the block read back what they drive.
      assign level_w[gi] = i_pin[gi];
    end
  endgenerate

  // ****************************************************************
  // Pin overrides: bus data and special functions
  // ****************************************************************
  // In non-multiplexed mode F and G become the host data bus and the
  // port registers stop steering them; the host owns the direction.
  wire bus_mode_w = i_nonmux_bus;

  // Ready/busy only takes pin 4 while programming runs, so the
  // pin keeps its port function the rest of the time.
  wire rb_sel_w = i_rdy_busy_enable & i_isp_active;
  // The battery flag holds pin 7 for as long as it is enabled.
  wire bat_sel_w = i_battery_flag_enable;

  // Port E pin values and enables with the special outputs folded in.
  // Pins 4 and 7 are the only special functions kept in this block.
  logic [7:0] e_out_w;
  logic [7:0] e_oe_w;
  always_comb begin
    e_out_w = pin_out_w[iocr_pkg::PORT_E];
    e_oe_w = oe_w[iocr_pkg::PORT_E];
    // Special outputs always drive, whatever the direction bit says.
    if (rb_sel_w) begin
      e_out_w[iocr_pkg::POS_READY_BUSY] = i_isp_ready;
      e_oe_w[iocr_pkg::POS_READY_BUSY] = 1'b1;
    end

    if (bat_sel_w) begin
      e_out_w[iocr_pkg::POS_BATTERY_ON] = i_battery_on_flag;
      e_oe_w[iocr_pkg::POS_BATTERY_ON] = 1'b1;
    end
  end

  // Final pin drive per port.
  // Ports default to their own registers; overrides follow.
  always_comb begin
    for (int p = 0; p < iocr_pkg::NUM_PORTS; p++) begin
      o_pin_out[p] = pin_out_w[p];
      o_pin_oe[p] = oe_w[p];
    end
    o_pin_out[iocr_pkg::PORT_E] = e_out_w;
    o_pin_oe[iocr_pkg::PORT_E] = e_oe_w;
    // The host data bus beats every port setting on F and G.
    if (bus_mode_w) begin
      o_pin_out[iocr_pkg::PORT_F] = i_host_data[7:0];
      o_pin_out[iocr_pkg::PORT_G] = i_host_data[15:8];
      o_pin_oe[iocr_pkg::PORT_F] = {8{i_host_data_drive}};
      o_pin_oe[iocr_pkg::PORT_G] = {8{i_host_data_drive}};
    end
  end

  // ****************************************************************
  // Macrocell flip-flops and their write locks
  // ****************************************************************
  // Macrocell flip-flops and their lock masks.
  logic [7:0] cells_a_reg;
  logic [7:0] cells_b_reg;
  logic [7:0] lock_a_reg;
  logic [7:0] lock_b_reg;

  // Host loads of the two macrocell groups.
  wire wr_cells_a_w = wr_w && off_w == iocr_pkg::OFF_LOGIC_CELLS_A_STATE;
  wire wr_cells_b_w = wr_w && off_w == iocr_pkg::OFF_LOGIC_CELLS_B_STATE;

  // Host load beats the logic clock-in on unlocked bits; a locked bit
  // keeps following the logic so a stray write cannot upset it.
  wire [7:0] load_a_w = wr_cells_a_w ? ~lock_a_reg : 8'h00;
  wire [7:0] load_b_w = wr_cells_b_w ? ~lock_b_reg : 8'h00;

  // Without a logic clock-in the flip-flops hold their value.
  wire [7:0] logic_a_w = i_cells_clock_en ? i_cells_a_next : cells_a_reg;
  wire [7:0] logic_b_w = i_cells_clock_en ? i_cells_b_next : cells_b_reg;
  // Bits the host does not load follow the logic path.
  wire [7:0] cells_a_next = (load_a_w & i_wdata) | (~load_a_w & logic_a_w);
  wire [7:0] cells_b_next = (load_b_w & i_wdata) | (~load_b_w & logic_b_w);

  // Macrocell state.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cells_a_reg <= iocr_pkg::RESET_BYTE;
      cells_b_reg <= iocr_pkg::RESET_BYTE;
    end else begin
      cells_a_reg <= cells_a_next;
      cells_b_reg <= cells_b_next;
    end
  end

  // Lock masks, clear at reset so writes are accepted by default.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lock_a_reg <= iocr_pkg::RESET_BYTE;
      lock_b_reg <= iocr_pkg::RESET_BYTE;
    end else begin
      if (wr_lock_a_w) lock_a_reg <= i_wdata;
      if (wr_lock_b_w) lock_b_reg <= i_wdata;
    end
  end

  // ****************************************************************
  // Miscellaneous writable registers
  // ****************************************************************
  // Plain host-written registers with no pin effect here.
  logic [7:0] page_reg;
  logic [7:0] placement_reg;
  logic debug_gate_reg;

  // Page, memory placement and debug-port gate.
  // Only bit 0 of the debug gate is stored; the rest read zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      page_reg <= iocr_pkg::RESET_BYTE;
      placement_reg <= iocr_pkg::RESET_PLACEMENT;
      debug_gate_reg <= 1'b0;
    end else begin
      if (wr_page_w) page_reg <= i_wdata;
      if (wr_place_w) placement_reg <= i_wdata;
      if (wr_debug_w) debug_gate_reg <= i_wdata[iocr_pkg::POS_DEBUG_ENABLE];
    end
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Status values are sampled at read time; undefined slots read zero.
  logic [7:0] rmux_w;
  always_comb begin
    rmux_w = 8'h00;
    // Port registers first; the single registers never share an offset.
    for (int p = 0; p < iocr_pkg::NUM_PORTS; p++) begin
      if (off_w == IN_OFF[p]) rmux_w = level_w[p];
      if (off_w == OUT_OFF[p]) rmux_w = out_latch_w[p];
      if (off_w == DIR_OFF[p]) rmux_w = dir_w[p];
      if (off_w == DRV_OFF[p]) rmux_w = drive_w[p];
      if (HAS_FUNC[p] && off_w == FUNC_OFF[p]) rmux_w = func_w[p];
    end

    // Registers outside the ports, one offset each.
    unique case (off_w)
      iocr_pkg::OFF_PORT_A_IN_CELLS: rmux_w = i_in_cells_a;
      iocr_pkg::OFF_PORT_B_IN_CELLS: rmux_w = i_in_cells_b;
      iocr_pkg::OFF_PORT_D_IN_CELLS: rmux_w = i_in_cells_d;
      iocr_pkg::OFF_PORT_A_OE_STATUS: rmux_w = o_pin_oe[iocr_pkg::PORT_A];
      iocr_pkg::OFF_PORT_B_OE_STATUS: rmux_w = o_pin_oe[iocr_pkg::PORT_B];
      iocr_pkg::OFF_PORT_C_OE_STATUS: rmux_w = o_pin_oe[iocr_pkg::PORT_C];
      iocr_pkg::OFF_PORT_F_OE_STATUS: rmux_w = o_pin_oe[iocr_pkg::PORT_F];
      iocr_pkg::OFF_LOGIC_CELLS_A_STATE: rmux_w = cells_a_reg;
      iocr_pkg::OFF_LOGIC_CELLS_B_STATE: rmux_w = cells_b_reg;
      iocr_pkg::OFF_LOGIC_CELLS_A_WRITE_LOCK: rmux_w = lock_a_reg;
      iocr_pkg::OFF_LOGIC_CELLS_B_WRITE_LOCK: rmux_w = lock_b_reg;
      iocr_pkg::OFF_PRIMARY_SECTOR_LOCK_STATUS: rmux_w = i_primary_sector_lock;
      iocr_pkg::OFF_SECONDARY_SECTOR_LOCK_STATUS: rmux_w = {i_security_set, 3'h0, i_secondary_sector_lock};
      iocr_pkg::OFF_DEBUG_PORT_GATE: rmux_w = {7'h00, debug_gate_reg};
      iocr_pkg::OFF_ADDRESS_PAGE_SELECT: rmux_w = page_reg;
      iocr_pkg::OFF_MEMORY_SPACE_PLACEMENT: rmux_w = placement_reg;
      iocr_pkg::OFF_MEMORY_SIZE_INFO0: rmux_w = iocr_pkg::MEM_SIZE_INFO0_VALUE;
      iocr_pkg::OFF_MEMORY_SIZE_INFO1: rmux_w = iocr_pkg::MEM_SIZE_INFO1_VALUE;
      default: ;
    endcase
  end

  // Read data is registered so it holds steady for the host's strobe.
  // Reads have no side effects, so a held read strobe only refreshes it.
  logic [7:0] rdata_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) rdata_reg <= iocr_pkg::RESET_BYTE;
    else if (rd_w) rdata_reg <= rmux_w;
  end

  // Outputs come straight from flip-flops, so no decode glitch
  // reaches the far side.
  assign o_rdata = rdata_reg;
  assign o_logic_cells_a = cells_a_reg;
  assign o_logic_cells_b = cells_b_reg;
  assign o_page_bits = page_reg;
  assign o_memory_space_placement = placement_reg;
  assign o_debug_port_enable = debug_gate_reg;

endmodule : iocr_top

// file: iocr_top_props.sv
module iocr_top_props (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Host access and observed state
  input wire logic i_register_window_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_offset,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_pin [7],
  input wire logic [7:0] o_pin_out [7],
  input wire logic [7:0] o_pin_oe [7],
  input wire logic [7:0] o_logic_cells_a,
  input wire logic [7:0] i_primary_sector_lock,
  input wire logic [3:0] i_secondary_sector_lock,
  input wire logic i_security_set
);
  // ****************************************************************
  // Read and write timing of the register window
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // A read or write of one offset is taken only with the window selected.
  function automatic logic rd_at(input logic [7:0] off);
    return i_register_window_select & i_rd & (i_offset == off);
  endfunction : rd_at
  function automatic logic wr_at(input logic [7:0] off);
    return i_register_window_select & i_wr & (i_offset == off);
  endfunction : wr_at

  a_unmapped_reads_zero: assert property (rd_at(8'h02) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_port_a_levels: assert property (rd_at(8'h00) |=> o_rdata == $past(i_pin[0])) else $error("port a level read");
  a_port_e_levels: assert property (rd_at(8'h30) |=> o_rdata == $past(i_pin[4])) else $error("port e level read");
  a_oe_status_read: assert property (rd_at(8'h0C) |=> o_rdata == $past(o_pin_oe[0])) else $error("oe status read");
  a_cells_read: assert property (rd_at(8'h20) |=> o_rdata == $past(o_logic_cells_a)) else $error("cell read");
  a_sector_status: assert property (rd_at(8'hC0) |=> o_rdata == $past(i_primary_sector_lock)) else $error("c0 read");
  a_boot_status: assert property (rd_at(8'hC2) |=> o_rdata == {$past(i_security_set), 3'h0,
    $past(i_secondary_sector_lock)}) else $error("c2 read");
  a_size_info: assert property (rd_at(8'hF0) |=> o_rdata == iocr_pkg::MEM_SIZE_INFO0_VALUE) else $error("f0 read");
  a_latch_drives_pin: assert property (wr_at(8'h04) |=> o_pin_out[0] == $past(i_wdata)) else $error("latch pin");
  a_dir_readback: assert property (wr_at(8'h06) ##1 rd_at(8'h06) |=> o_rdata == $past(i_wdata, 2))
    else $error("dir readback");
  a_rdata_holds: assert property (!(i_register_window_select & i_rd) |=> $stable(o_rdata)) else $error("rdata moved");

  // Main scenarios reached.
  c_lock_write: cover property (wr_at(8'h22));
  c_level_read: cover property (rd_at(8'h00));
  c_back_to_back: cover property (wr_at(8'h06) ##1 rd_at(8'h06));
endmodule : iocr_top_props

bind iocr_top iocr_top_props u_iocr_top_props (.*);

// file: iocr_host.sv
module iocr_host (
  // Clock and read data
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  // Host access
  output iocr_pkg::iocr_bus_t o_bus
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus idles deselected until the first access.
  initial o_bus = '0;

  // Held until the taking edge, so a back-to-back access simply follows it.
  task automatic access(input logic r, input logic w, input logic [7:0] off, input logic [7:0] wd,
                        output logic [7:0] rd);
    o_bus = '{1'b1, r, w, off, wd};
    @(posedge i_clock);
    #1;
    rd = i_rdata;
  endtask : access

  // Release the bus for one cycle so a held write is not repeated.
  task automatic idle();
    o_bus = '0;
    @(posedge i_clock);
    #1;
  endtask : idle
endmodule : iocr_host

// file: iocr_top_test.sv
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h, expected %h", $time, act, exp); end end
module iocr_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] off; logic [7:0] wd; logic [7:0] exp;} iocr_row_t;
  localparam iocr_row_t ROWS [18] = '{
    '{8'h04, 8'h55, 8'h55}, '{8'h06, 8'hA5, 8'hA5}, '{8'h08, 8'h3C, 8'h3C},
    '{8'h0C, 8'hFF, 8'hA1}, '{8'h18, 8'hC3, 8'hC3}, '{8'h42, 8'h0F, 8'h0F},
    '{8'h43, 8'hF0, 8'hF0}, '{8'hE2, 8'h1D, 8'h1D}, '{8'hC0, 8'hFF, 8'h96},
    '{8'hC2, 8'hFF, 8'h85}, '{8'hF0, 8'hFF, iocr_pkg::MEM_SIZE_INFO0_VALUE},
    '{8'hF1, 8'hFF, iocr_pkg::MEM_SIZE_INFO1_VALUE}, '{8'h02, 8'hFF, 8'h00},
    '{8'h11, 8'hFF, 8'hFF}, '{8'h0A, 8'hFF, 8'h5A}, '{8'h0B, 8'hFF, 8'h4B},
    '{8'h1A, 8'hFF, 8'hD1}, '{8'hE0, 8'h7E, 8'h7E}};
  logic i_clock = 0, i_rst = 1, nonmux = 0, hdrive = 0, isp_act = 0, isp_rdy = 0, rb_en = 0, bat = 0, bat_en = 0;
  logic cells_en = 0;
  logic [7:0] next_a = 8'h00, rd, o_rdata, o_cells_a, o_cells_b, o_page, o_place;
  logic [7:0] i_pin [7], o_pin_out [7], o_pin_oe [7];
  logic [7:0] cells_b_in = 8'h4B, cells_d_in = 8'hD1;
  logic o_debug, sec_set = 1;
  int num_errors = 0, total_checks = 0;
  iocr_pkg::iocr_bus_t bus;

  // Clock at 20 MHz.
  initial forever #25 i_clock = ~i_clock;

  // Pins are pulled up wherever no driver is enabled.
  always_comb for (int k = 0; k < 7; k++) i_pin[k] = (o_pin_oe[k] & o_pin_out[k]) | ~o_pin_oe[k];

  iocr_host u_iocr_host (.i_clock(i_clock), .i_rdata(o_rdata), .o_bus(bus));
  iocr_top u_iocr_top (.i_clock(i_clock), .i_rst(i_rst), .i_register_window_select(bus.sel), .i_rd(bus.rd),
    .i_wr(bus.wr), .i_offset(bus.offset), .i_wdata(bus.wdata), .o_rdata(o_rdata), .i_nonmux_bus(nonmux),
    .i_host_data_drive(hdrive), .i_host_data(16'h9A6B), .i_latched_addr(16'hC3E1), .i_pin(i_pin),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_in_cells_a(8'h5A), .i_in_cells_b(cells_b_in),
    .i_in_cells_d(cells_d_in), .i_cells_a_next(next_a), .i_cells_b_next(next_a), .i_cells_clock_en(cells_en),
    .o_logic_cells_a(o_cells_a), .o_logic_cells_b(o_cells_b), .o_page_bits(o_page),
    .i_primary_sector_lock(8'h96), .i_secondary_sector_lock(4'h5), .i_security_set(sec_set),
    .i_isp_active(isp_act), .i_isp_ready(isp_rdy), .i_rdy_busy_enable(rb_en),
    .i_battery_on_flag(bat), .i_battery_flag_enable(bat_en), .o_memory_space_placement(o_place),
    .o_debug_port_enable(o_debug));

  task automatic conclude();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (4000) @(posedge i_clock);
    num_errors++;
    conclude();
  end

  // Main sequence: table of write-then-read rows, then the awkward cases.
  initial begin
    repeat (2) @(posedge i_clock);
    #1 i_rst = 0;
    `CHK(o_pin_oe[0], 8'h00)
    u_iocr_host.access(1, 0, 8'h32, 8'h00, rd);
    `CHK(rd, 8'h00)
    foreach (ROWS[i]) begin
      u_iocr_host.access(0, 1, ROWS[i].off, ROWS[i].wd, rd);
      u_iocr_host.access(1, 0, ROWS[i].off, 8'h00, rd);
      `CHK(rd, ROWS[i].exp)
    end
    `CHK(o_place, 8'h1D)
    sec_set = 0;
    u_iocr_host.access(1, 0, 8'hC2, 8'h00, rd);
    `CHK(rd, 8'h05)
    u_iocr_host.access(0, 1, 8'h22, 8'h0F, rd);
    u_iocr_host.access(0, 1, 8'h20, 8'hFF, rd);
    `CHK(o_cells_a, 8'hF0)
    u_iocr_host.access(0, 1, 8'h21, 8'hA5, rd);
    u_iocr_host.access(1, 0, 8'h20, 8'h00, rd);
    `CHK(rd, 8'hF0)
    `CHK(o_cells_b, 8'hA5)
    u_iocr_host.access(0, 1, 8'hC7, 8'h01, rd);
    u_iocr_host.idle();
    `CHK(o_debug, 1'b1)
    cells_en = 1;
    next_a = 8'h3C;
    @(posedge i_clock);
    #1 cells_en = 0;
    `CHK(o_cells_a, 8'h3C)
    {isp_act, isp_rdy, rb_en, bat, bat_en} = 5'h1F;
    #1 `CHK(o_pin_out[4][4], 1'b1)
    `CHK(o_pin_out[4][7], 1'b1)
    {isp_act, isp_rdy, rb_en, bat, bat_en} = 5'h00;
    u_iocr_host.access(0, 1, 8'h32, 8'hFF, rd);
    u_iocr_host.idle();
    `CHK(o_pin_out[4], 8'hE1)
    `CHK(o_pin_out[6][7:4], 4'hC)
    {nonmux, hdrive} = 2'b11;
    #1 `CHK(o_pin_out[5], 8'h6B)
    `CHK(o_pin_out[6], 8'h9A)
    {nonmux, hdrive} = 2'b00;
    i_rst = 1;
    @(posedge i_clock);
    #1 i_rst = 0;
    `CHK(o_cells_b, 8'h00)
    `CHK(o_page, 8'h00)
    conclude();
  end
endmodule : iocr_top_test
